// ---- logic/mtop_top.v ----
// Purpose: Electronic thermal overload protection with Wishbone registers.
// Assumes: Current sample in 0.01 A units, synchronous to clk_i.
// Notes: Registers at byte offsets 0x00 to 0x1C; faults latch until reset.
`include "mtop_defs.vh"
`default_nettype none
module mtop_top #(
   parameter [15:0] INV_RATED = 16'h03E8,
   parameter SMALL_VARIANT = 0,
   parameter [15:0] PERIOD_US = `MTOP_PERIOD_US,
   parameter AW = 40
) (
   input wire clk_i,
   input wire reset_i,
   input wire [4:0] wb_adr_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   input wire wb_we_i,
   input wire [3:0] wb_sel_i,
   input wire wb_cyc_i,
   input wire wb_stb_i,
   output reg wb_ack_o,
   input wire [15:0] out_current_i,
   input wire [15:0] out_freq_i,
   input wire [2:0] term_in_i,
   output reg [2:0] term_out_o,
   output reg motor_overload_trip_o,
   output reg transistor_overload_trip_o,
   output reg prealarm_display_o
);
   localparam [4:0] A_SET1 = 5'h00;
   localparam [4:0] A_SET2 = 5'h04;
   localparam [4:0] A_MOTOR = 5'h08;
   localparam [4:0] A_INFN = 5'h0C;
   localparam [4:0] A_OUTFN = 5'h10;
   localparam [4:0] A_PWM = 5'h14;
   localparam [4:0] A_STAT = 5'h18;
   localparam [4:0] A_ACC = 5'h1C;
   localparam [31:0] TICK_CYC = PERIOD_US * `MTOP_CLK_MHZ;
   localparam [1:0] M_OFF = 2'h0;
   localparam [1:0] M_HEAT = 2'h1;
   localparam [1:0] M_COOL = 2'h2;
   // Scaling is done in 32 bits; in 16 bits the product overflows above about 7.7 A.
   localparam [31:0] SET1_SMALL = ({16'h0000, INV_RATED} * `MTOP_SMALL_PCT) / 32'd100;
   localparam [15:0] SET1_INIT = SMALL_VARIANT ? SET1_SMALL[15:0] : INV_RATED;

   reg [15:0] set1_q;
   reg [15:0] set2_q;
   reg [7:0] motor2_q;
   reg [7:0] infn_q [0:2];
   reg [7:0] outfn_q [0:2];
   reg [3:0] pwm_q;
   reg [31:0] tick_cnt_q;
   reg tick_q;
   reg [AW-1:0] tr_acc_q;
   wire [AW-1:0] acc1;
   wire [AW-1:0] acc2;
   wire pre1, pre2, trip1, trip2;

   // Select is the OR of every input terminal assigned to the select code.
   reg sel_d;
   integer k;
   integer j;
   integer m;
   always @*
   begin
      sel_d = 1'b0;
      for (k = 0; k < 3; k = k + 1)
         if (infn_q[k] == `MTOP_IN_FUNC_SELECT && term_in_i[k])
            sel_d = 1'b1;
   end
   wire second_set_select = sel_d;

   wire s1_zero = (set1_q == 16'h0000);
   wire s2_zero = (set2_q == 16'h0000);
   wire s2_inv = (set2_q == `MTOP_SET_INVALID);
   wire m2_cfg = (motor2_q != `MTOP_MOTOR_INVALID);

   // Truth table for per-motor heat, cool or inactive.
   reg [1:0] mode1, mode2;
   always @*
   begin
      mode1 = M_OFF;
      mode2 = M_OFF;
      if (!second_set_select)
      begin
         if (!s1_zero)
            mode1 = M_HEAT;
         if (!s2_zero && !s2_inv)
            mode2 = M_COOL;
         else if (s2_inv && m2_cfg && !s1_zero)
            mode2 = M_COOL;
      end
      else
      begin
         if (!s2_zero && !s2_inv)
         begin
            mode2 = M_HEAT;
            if (!s1_zero)
               mode1 = M_COOL;
         end
         else if (s2_inv && m2_cfg && !s1_zero)
         begin
            mode2 = M_HEAT;
            mode1 = M_COOL;
         end
         else if (s2_inv && !s1_zero)
            mode1 = M_HEAT;
         else if (s2_zero && !s1_zero)
            mode1 = M_COOL;
      end
      if (s1_zero)
         mode1 = M_OFF;
   end

   // With an invalid second setting the second motor uses the first setting.
   wire [15:0] ref2 = s2_inv ? set1_q : set2_q;
   // Constant-torque type keeps full gain down to 6 Hz; standard derates at low speed.
   wire ct1 = 1'b0;
   wire ct2 = m2_cfg && (motor2_q == 8'h01);
   function [3:0] gain_f;
      input ct;
      input [15:0] f;
      begin
         if (ct)
            gain_f = (f >= {8'h00, `MTOP_CT_FREQ_HZ}) ? 4'h1 : 4'h2;
         else
            gain_f = (f >= {8'h00, `MTOP_LOW_SPEED_HZ}) ? 4'h1 : 4'h2;
      end
   endfunction

   mtop_accum #(.AW(AW)) u_acc1 (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .tick_i(tick_q),
      .mode_i(mode1),
      .cur_i(out_current_i),
      .ref_i(set1_q),
      .gain_i(gain_f(ct1, out_freq_i)),
      .acc_o(acc1),
      .pre_o(pre1),
      .trip_o(trip1)
   );
   mtop_accum #(.AW(AW)) u_acc2 (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .tick_i(tick_q),
      .mode_i(mode2),
      .cur_i(out_current_i),
      .ref_i(ref2),
      .gain_i(gain_f(ct2, out_freq_i)),
      .acc_o(acc2),
      .pre_o(pre2),
      .trip_o(trip2)
   );

   // Transistor model always runs against the inverter rating; higher PWM code
   // adds heat faster, so the trip comes sooner.
   wire [31:0] i_sq = out_current_i * out_current_i;
   wire [31:0] r_sq = INV_RATED * INV_RATED;
   wire [AW-1:0] tr_heat = {{(AW-32){1'b0}}, i_sq} *
      {{(AW-5){1'b0}}, ({1'b0, pwm_q} + 5'h01)};
   wire [AW-1:0] tr_loss = {{(AW-32){1'b0}}, r_sq};
   wire [AW-1:0] tr_lim = {{(AW-36){1'b0}}, r_sq, 4'h0};
   wire [AW-1:0] tr_sum = tr_acc_q + tr_heat;

   reg prealarm;
   always @*
      prealarm = pre1 | pre2;

   always @(posedge clk_i)
   begin
      if (reset_i)
      begin
         tick_cnt_q <= 32'h00000000;
         tick_q <= 1'b0;
         tr_acc_q <= {AW{1'b0}};
         transistor_overload_trip_o <= 1'b0;
         motor_overload_trip_o <= 1'b0;
         prealarm_display_o <= 1'b0;
         term_out_o <= 3'h0;
      end
      else
      begin
         tick_q <= (tick_cnt_q == TICK_CYC - 32'h1);
         tick_cnt_q <= (tick_cnt_q == TICK_CYC - 32'h1) ? 32'h0 : tick_cnt_q + 32'h1;
         if (tick_q)
            tr_acc_q <= (tr_sum > tr_loss) ? tr_sum - tr_loss : {AW{1'b0}};
         if (tr_acc_q >= tr_lim)
            transistor_overload_trip_o <= 1'b1;
         if (trip1 | trip2)
            motor_overload_trip_o <= 1'b1;
         prealarm_display_o <= prealarm;
         for (j = 0; j < 3; j = j + 1)
            term_out_o[j] <= (outfn_q[j] == `MTOP_OUT_FUNC_POS) ? prealarm :
               (outfn_q[j] == `MTOP_OUT_FUNC_NEG) ? ~prealarm : 1'b0;
      end
   end

   // Wishbone slave: one-cycle ack, writes take effect on the ack edge.
   wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire [15:0] wr16 = wb_dat_i[15:0];
   always @(posedge clk_i)
   begin
      if (reset_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
         set1_q <= SET1_INIT;
         set2_q <= `MTOP_SET_INVALID;
         motor2_q <= `MTOP_MOTOR_INVALID;
         pwm_q <= 4'h1;
         for (m = 0; m < 3; m = m + 1)
         begin
            infn_q[m] <= 8'h00;
            outfn_q[m] <= 8'h00;
         end
      end
      else
      begin
         wb_ack_o <= wb_req;
         if (wb_req && wb_we_i && (&wb_sel_i[1:0]))
         begin
            case (wb_adr_i)
               // Tiny settings are taken, but protection near 5 percent of rating is weak.
               A_SET1: if (wr16 <= `MTOP_SET_MAX) set1_q <= wr16;
               A_SET2: if (wr16 <= `MTOP_SET_MAX || wr16 == `MTOP_SET_INVALID) set2_q <= wr16;
               A_MOTOR: motor2_q <= wb_dat_i[7:0];
               A_INFN:
               begin
                  infn_q[0] <= wb_dat_i[7:0];
                  infn_q[1] <= wb_dat_i[15:8];
                  infn_q[2] <= wb_dat_i[23:16];
               end
               A_OUTFN:
               begin
                  outfn_q[0] <= wb_dat_i[7:0];
                  outfn_q[1] <= wb_dat_i[15:8];
                  outfn_q[2] <= wb_dat_i[23:16];
               end
               A_PWM: pwm_q <= wb_dat_i[3:0];
               default: ;
            endcase
         end
         case (wb_adr_i)
            A_SET1: wb_dat_o <= {16'h0000, set1_q};
            A_SET2: wb_dat_o <= {16'h0000, set2_q};
            A_MOTOR: wb_dat_o <= {24'h000000, motor2_q};
            A_INFN: wb_dat_o <= {8'h00, infn_q[2], infn_q[1], infn_q[0]};
            A_OUTFN: wb_dat_o <= {8'h00, outfn_q[2], outfn_q[1], outfn_q[0]};
            A_PWM: wb_dat_o <= {28'h0000000, pwm_q};
            A_STAT: wb_dat_o <= {20'h00000, mode2, mode1, 1'b0, second_set_select,
               pre2, pre1, trip2, trip1, transistor_overload_trip_o,
               motor_overload_trip_o};
            A_ACC: wb_dat_o <= second_set_select ? acc2[AW-1:AW-32] : acc1[AW-1:AW-32];
            default: wb_dat_o <= 32'h00000000;
         endcase
      end
   end
endmodule
`default_nettype wire

// ---- logic/mtop_defs.vh ----
// Purpose: Constants for the motor thermal overload protection block.
// Assumes: Currents in units of 0.01 A; 100 MHz clock.
// Notes: Defines below hold the limits, codes and scale factors used by mtop_top and mtop_accum, except MTOP_FLOOR_PCT, which neither uses.
`ifndef MTOP_DEFS_VH
`define MTOP_DEFS_VH
`define MTOP_SET_MAX 16'hC350
`define MTOP_SET_INVALID 16'h270F
`define MTOP_MOTOR_INVALID 8'h63
`define MTOP_IN_FUNC_SELECT 8'h03
`define MTOP_OUT_FUNC_POS 8'h08
`define MTOP_OUT_FUNC_NEG 8'h6C
`define MTOP_PREALARM_PCT 8'h55
`define MTOP_SMALL_PCT 8'h55
`define MTOP_FLOOR_PCT 8'h05
`define MTOP_CT_FREQ_HZ 8'h06
`define MTOP_LOW_SPEED_HZ 8'h0F
`define MTOP_PERIOD_US 16'h0064
`define MTOP_CLK_MHZ 16'h0064
`endif

// ---- logic/mtop_accum.v ----
// Purpose: One thermal accumulator for one motor.
// Assumes: Update strobe once per control period.
// Notes: Heat adds I^2 minus reference^2 losses; cool uses zero current.
`default_nettype none
module mtop_accum #(
   parameter AW = 40
) (
   input wire clk_i,
   input wire reset_i,
   input wire tick_i,
   input wire [1:0] mode_i,
   input wire [15:0] cur_i,
   input wire [15:0] ref_i,
   input wire [3:0] gain_i,
   output reg [AW-1:0] acc_o,
   output reg pre_o,
   output reg trip_o
);
   localparam [1:0] M_OFF = 2'h0;
   localparam [1:0] M_HEAT = 2'h1;
   localparam [1:0] M_COOL = 2'h2;
   wire [31:0] i_sq = cur_i * cur_i;
   wire [31:0] r_sq = ref_i * ref_i;
   // Limit scales with the reference squared so trip time tracks the setting.
   wire [AW-1:0] limit = {{(AW-36){1'b0}}, r_sq, 4'h0};
   wire [AW-1:0] pre_lim = (limit / 8'd100) * `MTOP_PREALARM_PCT;
   wire [AW-1:0] heat_in = {{(AW-32){1'b0}}, i_sq} * {{(AW-4){1'b0}}, gain_i};
   wire [AW-1:0] loss = {{(AW-32){1'b0}}, r_sq};
   reg [AW-1:0] acc_d;
   always @*
   begin
      acc_d = acc_o;
      case (mode_i)
         M_HEAT: acc_d = acc_o + heat_in - ((acc_o + heat_in > loss) ? loss : acc_o + heat_in);
         M_COOL: acc_d = (acc_o > loss) ? acc_o - loss : {AW{1'b0}};
         default: acc_d = acc_o;
      endcase
   end
   always @(posedge clk_i)
   begin
      if (reset_i)
      begin
         acc_o <= {AW{1'b0}};
         pre_o <= 1'b0;
         trip_o <= 1'b0;
      end
      else
      begin
         if (tick_i)
            acc_o <= acc_d;
         pre_o <= (mode_i != M_OFF) && (acc_o >= pre_lim);
         if ((mode_i != M_OFF) && (acc_o >= limit))
            trip_o <= 1'b1;
      end
   end
endmodule
`default_nettype wire

// ---- dv/mtop_checker.sv ----
// Purpose: Port checks for the thermal overload block.
// Assumes: One clock, synchronous active-high reset.
// Notes: Bound to every mtop_top instance.
`default_nettype none
module mtop_checker (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [15:0] out_current_i,
   input wire logic motor_overload_trip_o,
   input wire logic transistor_overload_trip_o,
   input wire logic prealarm_display_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   mtrip_latch_a: assert property (motor_overload_trip_o |=> motor_overload_trip_o)
      else $error("motor trip cleared without reset");
   ttrip_latch_a: assert property (transistor_overload_trip_o |=> transistor_overload_trip_o)
      else $error("transistor trip cleared without reset");
   pre_first_a: assert property ($rose(motor_overload_trip_o) |-> prealarm_display_o)
      else $error("trip without prealarm");
   heat_cause_a: assert property ($rose(motor_overload_trip_o) |-> $past(out_current_i, 3) != 16'h0000)
      else $error("trip while current is zero");
   pre_cause_a: assert property ($rose(prealarm_display_o) |-> $past(out_current_i, 3) != 16'h0000)
      else $error("prealarm while current is zero");
   rel_clear_a: assert property ($fell(reset_i) |-> !motor_overload_trip_o && !prealarm_display_o)
      else $error("fault outputs set after reset");
   cover property ($rose(prealarm_display_o));
   cover property ($rose(motor_overload_trip_o));
   cover property (wb_ack_o);
endmodule
bind mtop_top mtop_checker u_chk (.clk_i(clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .out_current_i(out_current_i),
   .motor_overload_trip_o(motor_overload_trip_o),
   .transistor_overload_trip_o(transistor_overload_trip_o),
   .prealarm_display_o(prealarm_display_o));
`default_nettype wire

// ---- dv/mtop_load.sv ----
// Purpose: Current and frequency measurement seen by the block.
// Assumes: Current in 0.01 A units, frequency in Hz.
// Notes: Current and frequency follow the bench's command one cycle late.
`default_nettype none
module mtop_load (
   input wire logic clk_i,
   input wire logic [15:0] amps_i,
   input wire logic [15:0] hz_i,
   output var logic [15:0] out_current_o = 16'h0000,
   output var logic [15:0] out_freq_o = 16'h0000
);
   timeunit 1ns;
   timeprecision 1ps;
   // A sampled sensor never shows a step in the same cycle it happens.
   always @(posedge clk_i)
   begin
      out_current_o <= amps_i;
      out_freq_o <= hz_i;
   end
endmodule
`default_nettype wire

// ---- dv/mtop_bench.sv ----
// Purpose: Self-checking bench for the thermal overload block.
// Assumes: Control period shortened to 100 cycles.
// Notes: Modes in status are 0 off, 1 heat, 2 cool.
`default_nettype none
module mtop_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [4:0] wb_adr_i = 5'h00;
   logic [31:0] wb_dat_i = 32'h0;
   logic wb_we_i = 1'b0;
   logic [3:0] wb_sel_i = 4'h0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic [2:0] term_in_i = 3'h0;
   logic [15:0] amps = 16'h0000;
   logic [15:0] hz = 16'h0032;
   logic [31:0] wb_dat_o, rd;
   logic [15:0] cur, freq;
   logic [2:0] term_out_o;
   logic wb_ack_o, mtrip, ttrip, pre;
   int err_total = 0;
   int comparisons = 0;
   // Entry: set1, set2, motor2, terminals, expected {mode2, mode1}.
   localparam logic [47:0] TBL [8] = '{
      {16'h03E8, 16'h01F4, 8'h63, 4'h1, 4'h6}, {16'h03E8, 16'h01F4, 8'h63, 4'h0, 4'h9},
      {16'h03E8, 16'h0000, 8'h63, 4'h1, 4'h2}, {16'h0000, 16'h270F, 8'h63, 4'h1, 4'h0},
      {16'h03E8, 16'h270F, 8'h63, 4'h1, 4'h1}, {16'h03E8, 16'h270F, 8'h00, 4'h1, 4'h6},
      {16'h0000, 16'h01F4, 8'h00, 4'h1, 4'h4}, {16'h03E8, 16'h01F4, 8'h63, 4'h2, 4'h9}};
   mtop_load u_load (.clk_i(clk_i), .amps_i(amps), .hz_i(hz), .out_current_o(cur),
      .out_freq_o(freq));
   mtop_top #(.PERIOD_US(16'h0001)) u_dut (.clk_i(clk_i), .reset_i(reset_i),
      .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i),
      .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
      .out_current_i(cur), .out_freq_i(freq), .term_in_i(term_in_i), .term_out_o(term_out_o),
      .motor_overload_trip_o(mtrip), .transistor_overload_trip_o(ttrip),
      .prealarm_display_o(pre));
   always #5 clk_i = ~clk_i;
   task automatic chk(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1)
      begin
         err_total++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   task automatic wbx(input logic we, input logic [4:0] a, input logic [31:0] d,
      input logic [3:0] s);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      wb_sel_i <= s;
      @(posedge clk_i);
      while (wb_ack_o !== 1'b1 && n < 20)
      begin
         @(posedge clk_i);
         n++;
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk_i);
      chk(n < 20, "no bus answer");
   endtask
   task automatic rdc(input logic [4:0] a, input logic [31:0] e, input string msg);
      wbx(1'b0, a, 32'h0, 4'hF);
      chk(rd === e, msg);
   endtask
   task automatic waitfor(input int which, output int n);
      n = 0;
      while ((which == 0 ? pre : which == 1 ? mtrip : ttrip) !== 1'b1 && n < 3000)
      begin
         @(posedge clk_i);
         n++;
      end
   endtask
   task automatic t_regs;
      rdc(5'h00, 32'h000003E8, "first setting reset value");
      rdc(5'h04, 32'h0000270F, "second setting reset value");
      rdc(5'h08, 32'h00000063, "second motor reset value");
      wbx(1'b1, 5'h00, 32'h0000C351, 4'hF);
      rdc(5'h00, 32'h000003E8, "over-range first setting taken");
      wbx(1'b1, 5'h00, 32'h0000C350, 4'hF);
      rdc(5'h00, 32'h0000C350, "full-range first setting lost");
      wbx(1'b1, 5'h04, 32'h0000C351, 4'hF);
      wbx(1'b1, 5'h04, 32'h000001F4, 4'hC);
      rdc(5'h04, 32'h0000270F, "refused second setting taken");
      // A dual-rated motor of 9.09 A at 60 Hz is programmed as 1.1 times that.
      wbx(1'b1, 5'h00, 32'h000003E8, 4'hF);
      $display("test registers done");
   endtask
   task automatic t_trip;
      int w;
      // Lowest switching code gives the transistor model the same heat rate as the motor model.
      wbx(1'b1, 5'h14, 32'h00000000, 4'hF);
      wbx(1'b1, 5'h10, 32'h00006C08, 4'hF);
      amps <= 16'h07D0;
      waitfor(0, w);
      chk(pre === 1'b1 && mtrip === 1'b0, "prealarm before trip missing");
      repeat (2) @(posedge clk_i);
      chk(term_out_o[1:0] === 2'b01, "prealarm terminals wrong");
      rdc(5'h18, 32'h00000110, "status while heating wrong");
      waitfor(1, w);
      chk(mtrip === 1'b1, "no overload trip");
      amps <= 16'h0000;
      repeat (500) @(posedge clk_i);
      chk(mtrip === 1'b1, "trip cleared without reset");
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      chk(mtrip === 1'b0, "trip kept through reset");
      chk(ttrip === 1'b0, "transistor trip kept through reset");
      $display("test trip done");
   endtask
   task automatic t_table;
      wbx(1'b1, 5'h0C, 32'h00000003, 4'hF);
      for (int i = 0; i < 8; i++)
      begin
         wbx(1'b1, 5'h00, {16'h0, TBL[i][47:32]}, 4'hF);
         wbx(1'b1, 5'h04, {16'h0, TBL[i][31:16]}, 4'hF);
         wbx(1'b1, 5'h08, {24'h0, TBL[i][15:8]}, 4'hF);
         term_in_i <= TBL[i][6:4];
         @(posedge clk_i);
         wbx(1'b0, 5'h18, 32'h0, 4'hF);
         chk({rd[11:8], rd[6]} === {TBL[i][3:0], TBL[i][4]}, "mode table row");
      end
      $display("test mode table done");
   endtask
   // Two accumulator reads exactly one control period apart give one tick's heat.
   task automatic acc_step(output logic [31:0] d);
      logic [31:0] a0;
      wbx(1'b0, 5'h1C, 32'h0, 4'hF);
      a0 = rd;
      repeat (97) @(posedge clk_i);
      wbx(1'b0, 5'h1C, 32'h0, 4'hF);
      d = rd - a0;
   endtask
   task automatic t_curve;
      logic [31:0] d;
      wbx(1'b1, 5'h04, 32'h00000200, 4'hF);
      wbx(1'b1, 5'h08, 32'h00000001, 4'hF);
      term_in_i <= 3'h1;
      hz <= 16'h000A;
      amps <= 16'h0400;
      repeat (4) @(posedge clk_i);
      acc_step(d);
      chk(d === 32'h00000C00, "constant-torque heat wrong at 10 Hz");
      wbx(1'b1, 5'h08, 32'h00000000, 4'hF);
      acc_step(d);
      chk(d === 32'h00001C00, "standard derating missing at 10 Hz");
      amps <= 16'h0000;
      hz <= 16'h0032;
      $display("test thermal curve done");
   endtask
   task automatic rst_pulse;
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic t_pwm;
      int n0, n3;
      rst_pulse;
      wbx(1'b1, 5'h00, 32'h00000000, 4'hF);
      wbx(1'b1, 5'h14, 32'h00000000, 4'hF);
      amps <= 16'h05DC;
      waitfor(2, n0);
      chk(ttrip === 1'b1 && mtrip === 1'b0, "transistor protection lost");
      amps <= 16'h0000;
      rst_pulse;
      wbx(1'b1, 5'h14, 32'h00000003, 4'hF);
      amps <= 16'h05DC;
      waitfor(2, n3);
      chk(ttrip === 1'b1 && n3 < n0, "trip not sooner at higher code");
      amps <= 16'h0000;
      $display("test transistor protection done");
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      t_regs;
      t_trip;
      t_table;
      t_curve;
      t_pwm;
      report_and_stop;
   end
   initial
   begin
      #400000;
      err_total++;
      $display("unexpected at %0t: watchdog expired", $time);
      report_and_stop;
   end
endmodule
`default_nettype wire
